// *** src/phy_id_vendor_pkg.sv ***
// constants, register map and carrier types for the phy identification/vendor pages block
`default_nettype none
package phy_id_vendor_pkg;
    // register indices; byte address on the bus is four times the index
    localparam logic [3:0] IDX_PWR_CLASS = 4'h4; // power class and request status
    localparam logic [3:0] IDX_PAGE_SEL = 4'h7; // page select
    localparam logic [3:0] IDX_COMPLIANCE = 4'h8; // page 1: compliance level
    localparam logic [3:0] IDX_ID_RSVD = 4'h9; // page 1: reserved
    localparam logic [3:0] IDX_OUI_HI = 4'hA; // page 1: maker oui msb
    localparam logic [3:0] IDX_OUI_MID = 4'hB;
    localparam logic [3:0] IDX_OUI_LO = 4'hC;
    localparam logic [3:0] IDX_PART_HI = 4'hD; // page 1: part code msb
    localparam logic [3:0] IDX_PART_MID = 4'hE;
    localparam logic [3:0] IDX_PART_LO = 4'hF;
    localparam logic [3:0] IDX_ARB_CTRL = 4'h8; // page 7: flag and link rate
    // page select codes
    localparam logic [2:0] PAGE_IDENT = 3'h1;
    localparam logic [2:0] PAGE_VENDOR = 3'h7;
    localparam logic [2:0] PAGE_SEL_RST = 3'h0;
    // field positions
    localparam int NULL_ACT_BIT = 7; // null-packet flag sits in the msb of the byte
    localparam int LSPD_LO = 0; // link speed in the two lsbs
    localparam int PWR_LO = 0; // power class bits 2:0 of index 4
    localparam int FAIR_BIT = 4; // pending fair request, read only
    localparam int PRI_BIT = 5; // pending priority request, read only
    // fixed and reset values
    localparam logic [7:0] COMPLIANCE_LEVEL = 8'h01;
    localparam logic NULL_ACT_RST = 1'b0; // flag value after hardware reset
    localparam logic [1:0] SPD_S100 = 2'h0;
    localparam logic [1:0] SPD_S200 = 2'h1;
    localparam logic [1:0] SPD_S400 = 2'h2;
    localparam logic [1:0] SPD_ILLEGAL = 2'h3;
    localparam logic [1:0] LSPD_RST = SPD_S400;
    localparam logic [2:0] PWR_RST = 3'h0;
    localparam logic [2:0] PWR_RESERVED = 3'h5; // code 101 has no meaning
    localparam int ACK_BITS = 8; // an acknowledge carries exactly 8 bits
    localparam logic [1:0] STRAP_SETTLE = 2'h2; // cycles after release before latching
    // what the self-id transmitter picks up from this block
    typedef struct packed {
        logic [2:0] pwr; // power field, bits 21-23 of self-id
        logic [1:0] sp; // node speed, copied from link rate
        logic [1:0] phy_sp; // speed advertised to peer phys
    } self_id_info_t;
    // request state toward the arbiter
    typedef struct packed {
        logic fair; // fair request pending
        logic pri; // priority request pending
    } arb_req_t;
endpackage : phy_id_vendor_pkg
`default_nettype wire

// *** src/phy_id_vendor_regs.sv ***
// paged identification/vendor registers, request clearing and power class of the phy
//
// Operation
// RQ1: page select 1 maps the identification page
// RQ2: page select 7 maps the vendor page
// RQ3: compliance byte reads fixed 01h at 1000b
// RQ4: 24-bit maker oui, msb at 1010b
// RQ5: 24-bit part code, msb at 1101b
// RQ6: flag set: only packets over 8 bits clear
// RQ7: flag clear: any non-acknowledge packet clears requests
// RQ8: flag resets to 0, bus reset keeps it
// RQ9: link speed encodes s100/s200/s400; 11 illegal
// RQ10: link speed copied into self-id speed
// RQ11: phy always advertises s400 to peers
// RQ12: link speed resets to s400, bus-reset proof
// RQ13: straps give default self-id power field
// RQ14: straps latched after reset, register write overrides
// RQ15: power-class code meanings, 101 reserved
// RQ16: reserved locations read zero, writes ignored
//
// The APB interface to the registers was decided locally.
`default_nettype none
module phy_id_vendor_regs #(
    parameter logic [23:0] MAKER_OUI = 24'h5A5A5A, // arbitrary value, not a real maker
    parameter logic [23:0] PART_CODE = 24'hA5A5A5, // arbitrary value, not a real part
    parameter int PKT_LEN_W = 16 // width of the received packet bit count
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // power class strap pins, asynchronous
    input wire logic [2:0] power_class_straps,
    // arbiter side, same clock
    input wire logic fair_req_set,
    input wire logic pri_req_set,
    input wire logic pkt_rx_done,
    input wire logic [PKT_LEN_W-1:0] pkt_rx_bits,
    output phy_id_vendor_pkg::arb_req_t arb_req,
    // self-id contents
    output phy_id_vendor_pkg::self_id_info_t self_id_info
);
    import phy_id_vendor_pkg::*;

    logic [2:0] page_sel_r; // current page
    logic null_packet_action_flag_r; // keeps requests alive across short packets when set
    logic [1:0] link_speed_r; // attached link top speed
    logic [2:0] pwr_class_r; // power class field of index 4
    logic sw_pwr_wr_r; // software has written the power class
    logic strap_done_r; // straps have been latched
    logic [1:0] strap_cnt_r; // settle counter after reset release
    logic [2:0] strap_meta_r; // first synchroniser stage
    logic [2:0] strap_sync_r; // second synchroniser stage
    logic fair_r; // pending fair request
    logic pri_r; // pending priority request
    logic [31:0] prdata_r; // read data, captured in setup
    logic pslverr_r; // error answer, captured in setup
    logic [3:0] idx; // word index of the access
    logic wr_acc; // write takes effect this edge
    logic setup; // first cycle of a transfer
    logic pkt_clears; // received packet clears requests
    logic [31:0] rd_nxt; // read mux
    logic err_nxt; // unmapped index

    assign idx = paddr[5:2];
    assign setup = psel & ~penable;
    assign wr_acc = psel & penable & pwrite;
    // zero wait states: the answer is ready in the first access cycle
    assign pready = psel & penable;
    assign prdata = prdata_r;
    assign pslverr = pslverr_r & pready;

    // page select register; only 1 and 7 map anything, other values read back
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            page_sel_r <= PAGE_SEL_RST;
        end else if (wr_acc && idx == IDX_PAGE_SEL) begin
            page_sel_r <= pwdata[2:0];
        end
    end

    // vendor page control byte; hardware reset only, no bus reset input reaches it
    // rst_n is the only clear path, so the link can count on these settings
    // surviving every bus reset that the rest of the phy goes through
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            null_packet_action_flag_r <= NULL_ACT_RST; // [RQ8]
            link_speed_r <= LSPD_RST; // [RQ12]
        end else if (wr_acc && idx == IDX_ARB_CTRL && page_sel_r == PAGE_VENDOR) begin // [RQ2]
            null_packet_action_flag_r <= pwdata[NULL_ACT_BIT]; // [RQ8]
            // the illegal code is dropped so self-id never reports a bogus speed
            if (pwdata[LSPD_LO+1:LSPD_LO] != SPD_ILLEGAL) begin // [RQ9]
                link_speed_r <= pwdata[LSPD_LO+1:LSPD_LO];
            end
        end
    end

    // straps come from pins: two flops before anyone looks at them
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            strap_meta_r <= 3'h0;
            strap_sync_r <= 3'h0;
        end else begin
            strap_meta_r <= power_class_straps;
            strap_sync_r <= strap_meta_r;
        end
    end

    // settle counter: wait until the synchroniser holds real pin values
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            strap_cnt_r <= 2'h0;
            strap_done_r <= 1'b0;
        end else if (!strap_done_r) begin
            if (strap_cnt_r == STRAP_SETTLE) begin
                strap_done_r <= 1'b1;
            end else begin
                strap_cnt_r <= strap_cnt_r + 2'h1;
            end
        end
    end

    // power class: strap default once, any software write takes over for good
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pwr_class_r <= PWR_RST;
            sw_pwr_wr_r <= 1'b0;
        end else if (wr_acc && idx == IDX_PWR_CLASS) begin
            // a write in the latch cycle wins, so the override is never lost
            pwr_class_r <= pwdata[PWR_LO+2:PWR_LO]; // [RQ14]
            sw_pwr_wr_r <= 1'b1;
        end else if (!strap_done_r && strap_cnt_r == STRAP_SETTLE && !sw_pwr_wr_r) begin
            pwr_class_r <= strap_sync_r; // [RQ13]
        end
    end

    // which received packets release pending requests
    // flag set: acknowledges, null and short malformed packets keep requests pending
    // flag clear: everything but an exact acknowledge clears them
    always_comb begin
        if (null_packet_action_flag_r) begin
            pkt_clears = pkt_rx_done && (pkt_rx_bits > PKT_LEN_W'(ACK_BITS)); // [RQ6]
        end else begin
            pkt_clears = pkt_rx_done && (pkt_rx_bits != PKT_LEN_W'(ACK_BITS)); // [RQ7]
        end
    end

    // pending requests; a new request in the clearing cycle survives
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            fair_r <= 1'b0;
            pri_r <= 1'b0;
        end else begin
            if (fair_req_set) begin
                fair_r <= 1'b1;
            end else if (pkt_clears) begin
                fair_r <= 1'b0; // [RQ6] [RQ7]
            end
            if (pri_req_set) begin
                pri_r <= 1'b1;
            end else if (pkt_clears) begin
                pri_r <= 1'b0; // [RQ6] [RQ7]
            end
        end
    end

    assign arb_req.fair = fair_r;
    assign arb_req.pri = pri_r;
    // self-id fields; code 101 is passed through, choosing it is software's concern
    assign self_id_info.pwr = pwr_class_r; // [RQ13] [RQ15]
    assign self_id_info.sp = link_speed_r; // [RQ10]
    assign self_id_info.phy_sp = SPD_S400; // [RQ11]

    // read mux; paged indices answer by the current page, else zero
    always_comb begin
        rd_nxt = 32'h0;
        err_nxt = 1'b0;
        if (idx == IDX_PWR_CLASS) begin
            rd_nxt[PWR_LO+2:PWR_LO] = pwr_class_r;
            rd_nxt[FAIR_BIT] = fair_r;
            rd_nxt[PRI_BIT] = pri_r;
        end else if (idx == IDX_PAGE_SEL) begin
            rd_nxt[2:0] = page_sel_r;
        end else if (idx >= IDX_COMPLIANCE) begin
            if (page_sel_r == PAGE_IDENT) begin // [RQ1]
                case (idx)
                    IDX_COMPLIANCE: rd_nxt[7:0] = COMPLIANCE_LEVEL; // [RQ3]
                    IDX_OUI_HI: rd_nxt[7:0] = MAKER_OUI[23:16]; // [RQ4]
                    IDX_OUI_MID: rd_nxt[7:0] = MAKER_OUI[15:8];
                    IDX_OUI_LO: rd_nxt[7:0] = MAKER_OUI[7:0];
                    IDX_PART_HI: rd_nxt[7:0] = PART_CODE[23:16]; // [RQ5]
                    IDX_PART_MID: rd_nxt[7:0] = PART_CODE[15:8];
                    IDX_PART_LO: rd_nxt[7:0] = PART_CODE[7:0];
                    default: rd_nxt = 32'h0; // reserved byte [RQ16]
                endcase
            end else if (page_sel_r == PAGE_VENDOR && idx == IDX_ARB_CTRL) begin // [RQ2]
                rd_nxt[NULL_ACT_BIT] = null_packet_action_flag_r;
                rd_nxt[LSPD_LO+1:LSPD_LO] = link_speed_r;
            end
            // test-reserved bytes and unused pages read zero [RQ16]
        end else begin
            err_nxt = 1'b1; // nothing lives below the paged window here
        end
    end

    // read data and error captured in setup so the access phase sees flops
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata_r <= 32'h0;
            pslverr_r <= 1'b0;
        end else if (setup) begin
            prdata_r <= pwrite ? 32'h0 : rd_nxt;
            pslverr_r <= err_nxt;
        end
    end

    // ---------------- checks ----------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    a_compl_read_fixed: assert property ( // [RQ3]
        (setup && !pwrite && idx == IDX_COMPLIANCE && page_sel_r == PAGE_IDENT)
        |=> (prdata[7:0] == COMPLIANCE_LEVEL && pready))
        else $error("compliance byte wrong");

    a_oui_msb_read: assert property ( // [RQ4]
        (setup && !pwrite && idx == IDX_OUI_HI && page_sel_r == PAGE_IDENT)
        |=> prdata == {24'h0, MAKER_OUI[23:16]})
        else $error("maker oui msb wrong");

    a_part_msb_read: assert property ( // [RQ5]
        (setup && !pwrite && idx == IDX_PART_HI && page_sel_r == PAGE_IDENT)
        |=> prdata == {24'h0, PART_CODE[23:16]})
        else $error("part code msb wrong");

    a_vendor_ctrl_read: assert property ( // [RQ2]
        (setup && !pwrite && idx == IDX_ARB_CTRL && page_sel_r == PAGE_VENDOR)
        |=> (prdata[NULL_ACT_BIT] == null_packet_action_flag_r && prdata[1:0] == link_speed_r
             && prdata[6:2] == 5'h0))
        else $error("vendor control byte wrong");

    a_test_rsvd_zero: assert property ( // [RQ16]
        (setup && !pwrite && idx > IDX_ARB_CTRL && page_sel_r == PAGE_VENDOR)
        |=> prdata == 32'h0)
        else $error("test reserved byte not zero");

    a_null_strict_keep: assert property ( // [RQ6]
        (null_packet_action_flag_r && pkt_rx_done && pkt_rx_bits <= PKT_LEN_W'(ACK_BITS)
         && fair_r)
        |=> fair_r)
        else $error("short packet cleared fair request");

    a_null_clear_drop: assert property ( // [RQ7]
        (!null_packet_action_flag_r && pkt_rx_done && pkt_rx_bits != PKT_LEN_W'(ACK_BITS)
         && !pri_req_set) |=> !pri_r)
        else $error("non-ack packet left priority request");

    a_set_beats_clear: assert property ( // [RQ6]
        (fair_req_set && pkt_clears) |=> fair_r)
        else $error("request lost in clearing cycle");

    a_lspd_no_illegal: assert property ( // [RQ9]
        (wr_acc && idx == IDX_ARB_CTRL && page_sel_r == PAGE_VENDOR
         && pwdata[1:0] == SPD_ILLEGAL) |=> $stable(link_speed_r))
        else $error("illegal link speed stored");

    a_sid_speed_copy: assert property ( // [RQ10]
        (wr_acc && idx == IDX_ARB_CTRL && page_sel_r == PAGE_VENDOR
         && pwdata[1:0] != SPD_ILLEGAL) |=> self_id_info.sp == $past(pwdata[1:0]))
        else $error("self-id speed not copied");

    a_peer_s400: assert property ( // [RQ11]
        self_id_info.phy_sp == SPD_S400)
        else $error("peer speed not s400");

    a_strap_latch: assert property ( // [RQ13]
        (!strap_done_r && strap_cnt_r == STRAP_SETTLE && !sw_pwr_wr_r
         && !(wr_acc && idx == IDX_PWR_CLASS))
        |=> self_id_info.pwr == $past(strap_sync_r))
        else $error("strap power class not latched");

    a_pwr_override: assert property ( // [RQ14]
        (wr_acc && idx == IDX_PWR_CLASS) |=> (self_id_info.pwr == $past(pwdata[2:0]))
        ##1 (strap_done_r || self_id_info.pwr == $past(self_id_info.pwr)))
        else $error("power class write not kept");

    // identification page: the remaining bytes, the reserved one reads zero
    a_oui_mid_read: assert property ( // [RQ4]
        (setup && !pwrite && idx == IDX_OUI_MID && page_sel_r == PAGE_IDENT)
        |=> prdata == {24'h0, MAKER_OUI[15:8]})
        else $error("maker oui middle byte wrong");

    a_oui_lsb_read: assert property ( // [RQ4]
        (setup && !pwrite && idx == IDX_OUI_LO && page_sel_r == PAGE_IDENT)
        |=> prdata == {24'h0, MAKER_OUI[7:0]})
        else $error("maker oui lsb wrong");

    a_part_mid_read: assert property ( // [RQ5]
        (setup && !pwrite && idx == IDX_PART_MID && page_sel_r == PAGE_IDENT)
        |=> prdata == {24'h0, PART_CODE[15:8]})
        else $error("part code middle byte wrong");

    a_part_lsb_read: assert property ( // [RQ5]
        (setup && !pwrite && idx == IDX_PART_LO && page_sel_r == PAGE_IDENT)
        |=> prdata == {24'h0, PART_CODE[7:0]})
        else $error("part code lsb wrong");

    a_ident_rsvd_zero: assert property ( // [RQ16]
        (setup && !pwrite && idx == IDX_ID_RSVD && page_sel_r == PAGE_IDENT)
        |=> prdata == 32'h0)
        else $error("identification reserved byte not zero");

    // a page code other than 1 or 7 leaves the whole window empty
    a_other_page_zero: assert property ( // [RQ16]
        (setup && !pwrite && idx >= IDX_COMPLIANCE && page_sel_r != PAGE_IDENT
         && page_sel_r != PAGE_VENDOR) |=> prdata == 32'h0)
        else $error("unused page not zero");

    a_page_sel_take: assert property ( // [RQ1]
        (wr_acc && idx == IDX_PAGE_SEL) |=> page_sel_r == $past(pwdata[2:0]))
        else $error("page select not taken");

    // the control byte moves on a vendor-page write and on nothing else, so a
    // stray write to another page cannot disturb it
    a_flag_write: assert property ( // [RQ8]
        (wr_acc && idx == IDX_ARB_CTRL && page_sel_r == PAGE_VENDOR)
        |=> null_packet_action_flag_r == $past(pwdata[NULL_ACT_BIT]))
        else $error("null packet flag write lost");

    a_flag_hold: assert property ( // [RQ8]
        !(wr_acc && idx == IDX_ARB_CTRL && page_sel_r == PAGE_VENDOR)
        |=> $stable(null_packet_action_flag_r))
        else $error("null packet flag moved without a write");

    a_lspd_hold: assert property ( // [RQ12]
        !(wr_acc && idx == IDX_ARB_CTRL && page_sel_r == PAGE_VENDOR)
        |=> $stable(link_speed_r))
        else $error("link speed moved without a write");

    // pending requests: a set always lands, the flag decides what clears
    a_pri_set_lands: assert property ( // [RQ6]
        pri_req_set |=> pri_r)
        else $error("priority request not pending");

    a_strict_clear: assert property ( // [RQ6]
        (null_packet_action_flag_r && pkt_rx_done && pkt_rx_bits > PKT_LEN_W'(ACK_BITS)
         && !fair_req_set) |=> !fair_r)
        else $error("long packet left fair request");

    a_ack_keeps: assert property ( // [RQ7]
        (!null_packet_action_flag_r && pkt_rx_done && pkt_rx_bits == PKT_LEN_W'(ACK_BITS)
         && pri_r) |=> pri_r)
        else $error("acknowledge cleared priority request");

    // register bus: error only outside the mapped indices
    a_unmapped_err: assert property ( // [RQ16]
        (setup && idx < IDX_COMPLIANCE && idx != IDX_PWR_CLASS && idx != IDX_PAGE_SEL)
        |=> (pready && pslverr))
        else $error("unmapped index gave no error");

    a_mapped_no_err: assert property ( // [RQ1]
        (setup && (idx >= IDX_COMPLIANCE || idx == IDX_PWR_CLASS || idx == IDX_PAGE_SEL))
        |=> !pslverr)
        else $error("mapped index gave an error");

    // power class word and the reserved code, which is stored as written
    a_pwr_read: assert property ( // [RQ14]
        (setup && !pwrite && idx == IDX_PWR_CLASS) |=> prdata[2:0] == $past(pwr_class_r))
        else $error("power class read wrong");

    a_pwr_code_pass: assert property ( // [RQ15]
        (wr_acc && idx == IDX_PWR_CLASS && pwdata[2:0] == PWR_RESERVED)
        |=> self_id_info.pwr == PWR_RESERVED)
        else $error("reserved power code not passed through");

endmodule : phy_id_vendor_regs
`default_nettype wire

// *** verification/link_apb_model.sv ***
// apb master model standing in for the link-layer controller
`default_nettype none
module link_apb_model (
    input wire logic sys_clk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    timeunit 1ns;
    timeprecision 1ps;
    // idle bus from time zero
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end
    // one transfer: setup, then access held until pready is seen at an edge
    task automatic xfer(input logic wr, input logic [3:0] idx, input logic [31:0] wd,
                        output logic [31:0] rd, output logic err);
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {2'h0, idx, 2'h0};
        pwdata <= wd;
        @(posedge sys_clk);
        penable <= 1'b1;
        // wait as long as the slave needs; only the bench watchdog ends a hung transfer
        do begin
            @(posedge sys_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // released lines show the inverse, so a stale value cannot pass
        paddr <= ~paddr;
        pwdata <= ~pwdata;
    endtask : xfer
endmodule : link_apb_model
`default_nettype wire

// *** verification/phy_vendor_pages_power_class_tb.sv ***
// self-checking bench for the identification, vendor and power-class registers
`default_nettype none
module phy_vendor_pages_power_class_tb import phy_id_vendor_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [23:0] OUI = 24'h3C5A96; // arbitrary value
    localparam logic [23:0] PART = 24'hC3A569; // arbitrary value
    localparam logic [2:0] STRAPS = 3'h6; // strapped power class
    logic sys_clk, rst_n, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [2:0] straps;
    logic fair_req_set, pri_req_set, pkt_rx_done;
    logic [15:0] pkt_rx_bits;
    arb_req_t arb_req;
    self_id_info_t self_id_info;
    int fails, n_compared;
    phy_id_vendor_regs #(.MAKER_OUI(OUI), .PART_CODE(PART), .PKT_LEN_W(16)) uut (
        .sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .power_class_straps(straps), .fair_req_set(fair_req_set), .pri_req_set(pri_req_set),
        .pkt_rx_done(pkt_rx_done), .pkt_rx_bits(pkt_rx_bits), .arb_req(arb_req),
        .self_id_info(self_id_info));
    link_apb_model lnk (.sys_clk(sys_clk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    // 100 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    // single comparison point, counts every check
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [3:0] idx, input logic [31:0] d);
        lnk.xfer(1'b1, idx, d, rd, err);
        #1;
    endtask : wr
    task automatic rdr(input logic [3:0] idx);
        lnk.xfer(1'b0, idx, 32'h0, rd, err);
    endtask : rdr
    // self-id fields after strap latch
    task automatic t_reset_defaults();
        repeat (6) @(posedge sys_clk);
        #1;
        chk("pwr", {29'h0, self_id_info.pwr}, {29'h0, straps});
        chk("sp", {30'h0, self_id_info.sp}, {30'h0, SPD_S400});
        chk("phy_sp", {30'h0, self_id_info.phy_sp}, {30'h0, SPD_S400});
    endtask : t_reset_defaults
    // identification page contents, writes ignored
    task automatic t_ident_page();
        logic [7:0] eb [8];
        eb = '{COMPLIANCE_LEVEL, 8'h00, OUI[23:16], OUI[15:8], OUI[7:0],
               PART[23:16], PART[15:8], PART[7:0]};
        wr(IDX_PAGE_SEL, {29'h0, PAGE_IDENT});
        for (int i = 0; i < 8; i++) begin
            wr(4'(8 + i), 32'hFF);
            rdr(4'(8 + i));
            chk("ident byte", rd, {24'h0, eb[i]});
        end
    endtask : t_ident_page
    // vendor page: reset value, test bytes, link speed codes
    task automatic t_vendor_page();
        wr(IDX_PAGE_SEL, 32'h3);
        rdr(IDX_PAGE_SEL);
        chk("page select", rd, 32'h3);
        rdr(IDX_ARB_CTRL);
        chk("unused page", rd, 32'h0);
        wr(IDX_PAGE_SEL, {29'h0, PAGE_VENDOR});
        rdr(IDX_ARB_CTRL);
        chk("ctrl reset", rd, {30'h0, LSPD_RST});
        chk("mapped err", {31'h0, err}, 32'h0);
        for (int i = 9; i < 16; i++) begin
            wr(4'(i), 32'hFF);
            rdr(4'(i));
            chk("test byte", rd, 32'h0);
        end
        for (int s = 0; s < 3; s++) begin
            wr(IDX_ARB_CTRL, {30'h0, 2'(s)});
            rdr(IDX_ARB_CTRL);
            chk("speed", rd, {30'h0, 2'(s)});
            chk("sp", {30'h0, self_id_info.sp}, {30'h0, 2'(s)});
            chk("phy_sp", {30'h0, self_id_info.phy_sp}, {30'h0, SPD_S400});
        end
        // illegal code: flag taken, speed kept
        wr(IDX_ARB_CTRL, 32'h83);
        rdr(IDX_ARB_CTRL);
        chk("illegal speed", rd, 32'h82);
        rdr(4'h0);
        chk("unmapped err", {31'h0, err}, 32'h1);
    endtask : t_vendor_page
    // request clearing by packet length under both flag settings
    task automatic t_requests();
        int lens [4];
        logic keep;
        lens = '{0, 7, 8, 9};
        for (int f = 1; f >= 0; f--) begin
            wr(IDX_ARB_CTRL, {24'h0, f[0], 5'h0, SPD_S400});
            for (int k = 0; k < 4; k++) begin
                keep = f[0] ? (lens[k] <= 8) : (lens[k] == 8);
                @(posedge sys_clk);
                fair_req_set <= 1'b1;
                pri_req_set <= 1'b1;
                @(posedge sys_clk);
                fair_req_set <= 1'b0;
                pri_req_set <= 1'b0;
                pkt_rx_done <= 1'b1;
                pkt_rx_bits <= 16'(lens[k]);
                @(posedge sys_clk);
                pkt_rx_done <= 1'b0;
                #1;
                chk("pending", {30'h0, arb_req.fair, arb_req.pri}, {30'h0, keep, keep});
            end
        end
    endtask : t_requests
    // software power class overrides the straps, every code passes through
    task automatic t_power_class();
        @(posedge sys_clk);
        fair_req_set <= 1'b1;
        @(posedge sys_clk);
        fair_req_set <= 1'b0;
        rdr(IDX_PWR_CLASS);
        chk("pwr reg", rd, {27'h0, 1'b1, 1'b0, STRAPS});
        for (int c = 0; c < 8; c++) begin
            wr(IDX_PWR_CLASS, {29'h0, 3'(c)});
            chk("pwr", {29'h0, self_id_info.pwr}, {29'h0, 3'(c)});
            rdr(IDX_PWR_CLASS);
            chk("pwr reg", rd, {27'h0, 1'b1, 1'b0, 3'(c)});
        end
    endtask : t_power_class
    // second hardware reset restores flag, speed and strap class
    task automatic t_hw_reset();
        wr(IDX_ARB_CTRL, 32'h81);
        @(posedge sys_clk);
        straps <= 3'h3;
        rst_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        t_reset_defaults();
        wr(IDX_PAGE_SEL, {29'h0, PAGE_VENDOR});
        rdr(IDX_ARB_CTRL);
        chk("ctrl after reset", rd, {30'h0, LSPD_RST});
    endtask : t_hw_reset
    task automatic give_verdict();
        if (fails == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : give_verdict
    // main sequence
    initial begin
        rst_n = 1'b0;
        straps = STRAPS;
        fair_req_set = 1'b0;
        pri_req_set = 1'b0;
        pkt_rx_done = 1'b0;
        pkt_rx_bits = 16'h0;
        fails = 0;
        n_compared = 0;
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        t_reset_defaults();
        t_ident_page();
        t_vendor_page();
        t_requests();
        t_power_class();
        t_hw_reset();
        give_verdict();
    end
    // watchdog: the run needs well under a thousand cycles
    initial begin
        #100000;
        fails++;
        give_verdict();
    end
endmodule : phy_vendor_pages_power_class_tb
`default_nettype wire
